//--- core/nva_consts.vh
// Constants for the byte non-volatile memory access register block
`ifndef NVA_CONSTS_VH
`define NVA_CONSTS_VH

// I/O space layout
`define NVA_IO_LAST 8'h3f
`define NVA_BIT_LAST 8'h1f
`define NVA_DS_OFFSET 8'h20
`define NVA_DS_LAST 8'h5f

// Register offsets in I/O space
`define NVA_OFS_CONTROL 8'h1c
`define NVA_OFS_DATA 8'h1d
`define NVA_OFS_PTR_LOW 8'h1e
`define NVA_OFS_PTR_HIGH 8'h1f

// Control register field positions
`define NVA_CTL_READ 0
`define NVA_CTL_TRIG 1
`define NVA_CTL_ARM 2
`define NVA_CTL_RIE 3
`define NVA_CTL_ACT_LO 4
`define NVA_CTL_ACT_HI 5

// Action select encodings
`define NVA_ACT_ATOMIC 2'b00
`define NVA_ACT_ERASE 2'b01
`define NVA_ACT_WRITE 2'b10
`define NVA_ACT_RSVD 2'b11

// Reset values
`define NVA_RST_ACT 2'b00
`define NVA_RST_DATA 8'h00

// Timing, times in microseconds, clock in MHz
`define NVA_CLK_MHZ 100
`define NVA_ATOMIC_US 3400
`define NVA_SPLIT_US 1800
`define NVA_ARM_CYC 3'h4
`define NVA_PROG_STALL_CYC 3'h2
`define NVA_READ_STALL_CYC 3'h4

`endif

//--- core/nva_regs.v
// Register interface and programming sequencer for the byte non-volatile store
//
// Overview of operation
// R1 - Bit set, clear, test on 0x00-0x1F only
// R2 - I/O ports 0x00-0x3F; data space adds 0x20
// R3 - Bit operations leave other flags untouched
// R4 - Reserved bits read zero; software writes zero
// R5 - Nine-bit pointer, high bit plus low byte
// R6 - Pointer undefined after reset; software loads it
// R7 - Data buffer feeds writes, captures read bytes
// R8 - Action select: atomic, erase, write, reserved
// R9 - Action select frozen while programming runs
// R10 - Reset clears action select unless busy
// R11 - Ready interrupt while enabled, global on, idle
// R12 - Arm bit self-clears four cycles later
// R13 - Trigger starts action only while armed
// R14 - Trigger stays set for programming time
// R15 - Trigger start stalls core two cycles
// R16 - Read strobe fetches byte, stalls four cycles
// R17 - No reads or pointer changes while busy
// R18 - Software polls trigger before reading
// R19 - Software never writes reserved addresses
// R20 - Reset does not abort running programming
// R21 - Write-only targets must be pre-erased
// R22 - Busy timer loaded per action, clears trigger
`timescale 1ns/1ps
`include "nva_consts.vh"

module nva_regs #(
    parameter ATOMIC_CYC = `NVA_ATOMIC_US * `NVA_CLK_MHZ,
    parameter SPLIT_CYC = `NVA_SPLIT_US * `NVA_CLK_MHZ,
    parameter TMR_W = 20,
    parameter PTR_W = 9
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire resetn_i,
    // Core register access
    input wire [7:0] addr_i,
    input wire io_space_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    output wire [7:0] rdata_o,
    // Core single-bit operations
    input wire bit_set_i,
    input wire bit_clr_i,
    input wire bit_test_i,
    input wire [2:0] bit_sel_i,
    output wire bit_val_o,
    // Core control
    input wire gie_i,
    output wire cpu_stall_o,
    output wire irq_o,
    // Storage array
    input wire [7:0] nvm_rdata_i,
    output wire [PTR_W-1:0] nvm_addr_o,
    output wire [7:0] nvm_wdata_o,
    output wire nvm_erase_o,
    output wire nvm_write_o,
    output wire nvm_rd_o
);

    localparam [TMR_W-1:0] ATOMIC_LOAD = ATOMIC_CYC[TMR_W-1:0];
    localparam [TMR_W-1:0] SPLIT_LOAD = SPLIT_CYC[TMR_W-1:0];
    localparam [TMR_W-1:0] TMR_ZERO = {TMR_W{1'b0}};

    // Address decode
    reg [7:0] io_addr;
    reg addr_ok;
    reg bit_ok;
    reg [7:0] bit_mask;
    reg [7:0] wmask;
    reg [7:0] wval;
    reg any_wr;
    reg sel_ctl;
    reg sel_data;
    reg sel_plo;
    reg sel_phi;

    // State
    reg [1:0] act_q;
    reg [1:0] act_d;
    reg rie_q;
    reg rie_d;
    reg [2:0] arm_cnt_q;
    reg [2:0] arm_cnt_d;
    reg busy_q;
    reg busy_d;
    reg [TMR_W-1:0] tmr_q;
    reg [TMR_W-1:0] tmr_d;
    reg [7:0] data_q;
    reg [7:0] data_d;
    reg [PTR_W-1:0] ptr_q;
    reg [PTR_W-1:0] ptr_d;
    reg [2:0] stall_cnt_q;
    reg [2:0] stall_cnt_d;
    reg erase_q;
    reg erase_d;
    reg write_q;
    reg write_d;
    reg [7:0] wbuf_q;
    reg [7:0] wbuf_d;
    reg rd_pulse_q;
    reg rd_pulse_d;
    reg [7:0] rdata_q;
    reg bit_val_q;
    reg stall_q;
    reg irq_q;
    reg [PTR_W-1:0] addr_q;

    // Register images
    reg [7:0] ctl_view;
    reg [7:0] cur_view;
    reg start;
    reg fetch;

    always @* begin
        // Data-space addresses map down onto I/O addresses
        io_addr = io_space_i ? addr_i : (addr_i - `NVA_DS_OFFSET); // [R2]
        addr_ok = io_space_i ? (addr_i <= `NVA_IO_LAST)
                             : (addr_i >= `NVA_DS_OFFSET && addr_i <= `NVA_DS_LAST); // [R2]
        bit_ok = io_space_i && (addr_i <= `NVA_BIT_LAST); // [R1]
        sel_ctl = addr_ok && (io_addr == `NVA_OFS_CONTROL);
        sel_data = addr_ok && (io_addr == `NVA_OFS_DATA);
        sel_plo = addr_ok && (io_addr == `NVA_OFS_PTR_LOW);
        sel_phi = addr_ok && (io_addr == `NVA_OFS_PTR_HIGH);
        bit_mask = 8'h01 << bit_sel_i;
        // Bit operations touch only the addressed bit
        if (wr_i) begin
            wmask = 8'hff;
            wval = wdata_i;
            any_wr = 1'b1;
        end else if ((bit_set_i || bit_clr_i) && bit_ok) begin
            wmask = bit_mask; // [R1] [R3]
            wval = bit_set_i ? bit_mask : 8'h00;
            any_wr = 1'b1;
        end else begin
            wmask = 8'h00;
            wval = 8'h00;
            any_wr = 1'b0;
        end
    end

    always @* begin
        // Read strobe always reads back as zero
        ctl_view = 8'h00; // [R4]
        ctl_view[`NVA_CTL_ACT_HI:`NVA_CTL_ACT_LO] = act_q;
        ctl_view[`NVA_CTL_RIE] = rie_q;
        ctl_view[`NVA_CTL_ARM] = (arm_cnt_q != 3'h0);
        ctl_view[`NVA_CTL_TRIG] = busy_q;
        cur_view = 8'h00;
        if (sel_ctl) begin
            cur_view = ctl_view;
        end else if (sel_data) begin
            cur_view = data_q;
        end else if (sel_plo) begin
            cur_view = ptr_q[7:0];
        end else if (sel_phi) begin
            cur_view = {7'h00, ptr_q[PTR_W-1]}; // [R4] [R5]
        end
    end

    always @* begin
        act_d = act_q;
        rie_d = rie_q;
        arm_cnt_d = (arm_cnt_q != 3'h0) ? arm_cnt_q - 3'h1 : 3'h0; // [R12]
        busy_d = busy_q;
        tmr_d = tmr_q;
        data_d = data_q;
        ptr_d = ptr_q;
        stall_cnt_d = (stall_cnt_q != 3'h0) ? stall_cnt_q - 3'h1 : 3'h0;
        erase_d = erase_q;
        write_d = write_q;
        wbuf_d = wbuf_q;
        rd_pulse_d = 1'b0;
        start = 1'b0;
        fetch = 1'b0;

        // Busy timer runs down; expiry ends the operation
        if (busy_q) begin
            if (tmr_q == TMR_ZERO || tmr_q == {{(TMR_W-1){1'b0}}, 1'b1}) begin
                busy_d = 1'b0; // [R14] [R22]
                tmr_d = TMR_ZERO;
                erase_d = 1'b0;
                write_d = 1'b0;
            end else begin
                tmr_d = tmr_q - {{(TMR_W-1){1'b0}}, 1'b1}; // [R22]
            end
        end

        if (any_wr && sel_ctl) begin
            if (wmask[`NVA_CTL_RIE]) begin
                rie_d = wval[`NVA_CTL_RIE]; // [R11]
            end
            // Mode bits cannot change under a running operation
            if (!busy_q) begin
                if (wmask[`NVA_CTL_ACT_LO]) begin
                    act_d[0] = wval[`NVA_CTL_ACT_LO]; // [R9]
                end
                if (wmask[`NVA_CTL_ACT_HI]) begin
                    act_d[1] = wval[`NVA_CTL_ACT_HI]; // [R9]
                end
            end
            // Arm window restarts on every written one except in a write that starts an operation
            if (wmask[`NVA_CTL_ARM] && wval[`NVA_CTL_ARM]) begin
                arm_cnt_d = `NVA_ARM_CYC; // [R12]
            end
            // Trigger only counts inside the arm window
            if (wmask[`NVA_CTL_TRIG] && wval[`NVA_CTL_TRIG] && !busy_q
                    && arm_cnt_q != 3'h0 && act_q != `NVA_ACT_RSVD) begin
                start = 1'b1; // [R13]
            end
            // Reads refused while programming runs
            if (wmask[`NVA_CTL_READ] && wval[`NVA_CTL_READ] && !busy_q) begin
                fetch = 1'b1; // [R16] [R17]
            end
        end

        if (start) begin
            busy_d = 1'b1; // [R14]
            tmr_d = (act_q == `NVA_ACT_ATOMIC) ? ATOMIC_LOAD : SPLIT_LOAD; // [R8] [R22]
            erase_d = (act_q != `NVA_ACT_WRITE); // [R8]
            write_d = (act_q != `NVA_ACT_ERASE); // [R8]
            wbuf_d = data_q; // [R7]
            // One arming buys one operation
            arm_cnt_d = 3'h0;
            stall_cnt_d = `NVA_PROG_STALL_CYC; // [R15]
        end

        if (any_wr && sel_data) begin
            data_d = (data_q & ~wmask) | (wval & wmask);
        end
        if (fetch) begin
            data_d = nvm_rdata_i; // [R7] [R16]
            rd_pulse_d = 1'b1;
            stall_cnt_d = `NVA_READ_STALL_CYC; // [R16]
        end

        // Pointer locked while programming runs
        if (any_wr && !busy_q) begin
            if (sel_plo) begin
                ptr_d[7:0] = (ptr_q[7:0] & ~wmask) | (wval & wmask); // [R5] [R17]
            end
            if (sel_phi && wmask[0]) begin
                ptr_d[PTR_W-1] = wval[0]; // [R5] [R17]
            end
        end
    end

    // Pointer carries no reset value; software must load it first
    always @(posedge sys_clk_i) begin
        ptr_q <= ptr_d; // [R6]
    end

    // A running operation survives reset to completion
    // Unknown busy at power-up takes the reset branch, so it settles idle
    always @(posedge sys_clk_i) begin
        if (resetn_i || busy_q) begin
            act_q <= act_d; // [R9] [R10] [R20]
            busy_q <= busy_d; // [R14] [R20]
            tmr_q <= tmr_d; // [R20] [R22]
            erase_q <= erase_d; // [R20]
            write_q <= write_d; // [R20]
            wbuf_q <= wbuf_d; // [R7] [R20]
        end else begin
            act_q <= `NVA_RST_ACT; // [R10]
            busy_q <= 1'b0;
            tmr_q <= TMR_ZERO;
            erase_q <= 1'b0;
            write_q <= 1'b0;
            wbuf_q <= `NVA_RST_DATA;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rie_q <= 1'b0;
            arm_cnt_q <= 3'h0;
            data_q <= `NVA_RST_DATA;
            stall_cnt_q <= 3'h0;
            rd_pulse_q <= 1'b0;
            addr_q <= ptr_q;
        end else begin
            rie_q <= rie_d;
            arm_cnt_q <= arm_cnt_d;
            data_q <= data_d;
            stall_cnt_q <= stall_cnt_d;
            rd_pulse_q <= rd_pulse_d;
            addr_q <= ptr_d;
        end
    end

    // Core-facing outputs straight from flops; read data, bit value and stall idle at zero
    always @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
            bit_val_q <= 1'b0;
            stall_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rd_i ? cur_view : 8'h00;
            // Bit test is meaningful only in the low bit-addressable range
            bit_val_q <= (bit_test_i && bit_ok) ? cur_view[bit_sel_i] : 1'b0; // [R1]
            stall_q <= (stall_cnt_d != 3'h0); // [R15] [R16]
            irq_q <= rie_d && gie_i && !busy_d; // [R11]
        end
    end

    assign rdata_o = rdata_q;
    assign bit_val_o = bit_val_q;
    assign cpu_stall_o = stall_q;
    assign irq_o = irq_q;
    assign nvm_addr_o = addr_q;
    assign nvm_wdata_o = wbuf_q;
    assign nvm_erase_o = erase_q;
    assign nvm_write_o = write_q;
    assign nvm_rd_o = rd_pulse_q;

endmodule // nva_regs

//--- verif/nva_regs_chk.sv
// Port checker for the byte store access block
`timescale 1ns/1ps
module nva_regs_chk #(
    parameter ATOMIC_CYC = 340000,
    parameter SPLIT_CYC = 180000,
    parameter PTR_W = 9
) (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire rd_i,
    input wire bit_test_i,
    input wire gie_i,
    input wire [7:0] rdata_o,
    input wire bit_val_o,
    input wire cpu_stall_o,
    input wire irq_o,
    input wire [PTR_W-1:0] nvm_addr_o,
    input wire [7:0] nvm_wdata_o,
    input wire nvm_erase_o,
    input wire nvm_write_o,
    input wire nvm_rd_o
);
    wire busy = nvm_erase_o | nvm_write_o;
    // Run length survives reset, as programming does
    reg [31:0] run_q = 32'h0;
    always @(posedge sys_clk_i) begin
        run_q <= busy ? run_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_rdata_idle:
        assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    a_bit_idle:
        assert property (!bit_test_i |=> !bit_val_o) else $error("bit value not idle");
    a_op_length:
        assert property ($fell(busy) |-> run_q == ($past(nvm_erase_o & nvm_write_o) ?
            ATOMIC_CYC : SPLIT_CYC)) else $error("programming time wrong");
    a_prog_stall:
        assert property ($rose(busy) |-> cpu_stall_o ##1 cpu_stall_o ##1 !cpu_stall_o)
            else $error("program stall wrong");
    a_read_stall:
        assert property (nvm_rd_o |-> cpu_stall_o [*4] ##1 !cpu_stall_o)
            else $error("read stall wrong");
    a_read_once:
        assert property (nvm_rd_o |=> !nvm_rd_o) else $error("read pulse too long");
    a_no_read_busy:
        assert property (busy && $past(busy) |-> !nvm_rd_o) else $error("read while busy");
    a_ptr_frozen:
        assert property (busy && $past(busy) |-> $stable(nvm_addr_o)) else $error("pointer moved");
    a_wdata_frozen:
        assert property (busy && $past(busy) |-> $stable(nvm_wdata_o)) else $error("data moved");
    a_irq_busy:
        assert property (busy |-> !irq_o) else $error("irq while busy");
    a_irq_gie:
        assert property (!gie_i |=> !irq_o) else $error("irq without global enable");
endmodule // nva_regs_chk

//--- verif/nva_array_model.sv
// Byte storage array model facing the access block
`timescale 1ns/1ps
module nva_array_model (
    input wire sys_clk_i,
    input wire [8:0] addr_i,
    input wire [7:0] wdata_i,
    input wire erase_i,
    input wire write_i,
    output wire [7:0] rdata_o
);
    reg [7:0] mem_q [0:511];
    reg busy_q = 1'b0;
    integer i;
    initial for (i = 0; i < 512; i = i + 1) mem_q[i] = i[7:0];
    assign rdata_o = mem_q[addr_i];
    always @(posedge sys_clk_i) begin
        busy_q <= erase_i | write_i;
        // Write alone only clears bits, so unerased cells lose data
        if ((erase_i | write_i) && !busy_q)
            mem_q[addr_i] <= !write_i ? 8'hff : erase_i ? wdata_i : mem_q[addr_i] & wdata_i;
    end
endmodule // nva_array_model

//--- verif/nva_regs_tb.sv
// Self-checking bench for the byte store access block
`timescale 1ns/1ps
module nva_regs_tb;
    reg sys_clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg io_space_i = 1'b1;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [7:0] wdata_i = 8'h00;
    reg bit_set_i = 1'b0;
    reg bit_clr_i = 1'b0;
    reg bit_test_i = 1'b0;
    reg [2:0] bit_sel_i = 3'h0;
    reg gie_i = 1'b1;
    wire [7:0] rdata_o, nvm_rdata_i, nvm_wdata_o;
    wire [8:0] nvm_addr_o;
    wire bit_val_o, cpu_stall_o, irq_o, nvm_erase_o, nvm_write_o, nvm_rd_o;
    integer errors = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer k, a;
    reg [8:0] p;
    reg [7:0] d, old;
    reg [31:0] rnd;
    reg [1:0] act;
    nva_regs #(.ATOMIC_CYC(40), .SPLIT_CYC(20)) dut_u (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .addr_i(addr_i), .io_space_i(io_space_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .bit_set_i(bit_set_i),
        .bit_clr_i(bit_clr_i), .bit_test_i(bit_test_i), .bit_sel_i(bit_sel_i),
        .bit_val_o(bit_val_o), .gie_i(gie_i), .cpu_stall_o(cpu_stall_o), .irq_o(irq_o),
        .nvm_rdata_i(nvm_rdata_i), .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
        .nvm_erase_o(nvm_erase_o), .nvm_write_o(nvm_write_o), .nvm_rd_o(nvm_rd_o));
    nva_array_model mem_u (.sys_clk_i(sys_clk_i), .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o),
        .erase_i(nvm_erase_o), .write_i(nvm_write_o), .rdata_o(nvm_rdata_i));
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            results;
        end
    end
    function [7:0] f_store(input [1:0] m, input [7:0] o, input [7:0] v);
        f_store = (m == 2'd0) ? v : (m == 2'd1) ? 8'hff : (m == 2'd2) ? (o & v) : o;
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One access per call; bk selects set, clear, test; none with w low is a read
    task acc(input [7:0] ad, input io, input w, input [2:0] bk, input [2:0] s, input [7:0] dt);
        begin
            k = 0;
            while (cpu_stall_o !== 1'b0 && k < 20) begin
                @(posedge sys_clk_i);
                #1 k = k + 1;
            end
            {addr_i, io_space_i, wr_i, rd_i, wdata_i, bit_sel_i} = {ad, io, w, !w && !bk, dt, s};
            {bit_test_i, bit_clr_i, bit_set_i} = bk;
            @(posedge sys_clk_i);
            {wr_i, rd_i, bit_test_i, bit_clr_i, bit_set_i} <= 5'h00;
            #1;
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        rnd = $urandom(32'h2004);
        repeat (2) @(posedge sys_clk_i);
        #1 resetn_i = 1'b1;
        acc(8'h1c, 1, 0, 0, 0, 0);
        chk(rdata_o, 8'h00);
        acc(8'h1d, 1, 0, 0, 0, 0);
        chk(rdata_o, 8'h00);
        $display("reset values done");
        rnd = $urandom;
        d = rnd[7:0];
        // Only mapped addresses written, reserved bits as zero
        acc(8'h3d, 0, 1, 0, 0, d);
        acc(8'h1d, 1, 0, 0, 0, 0);
        chk(rdata_o, d);
        acc(8'h1f, 1, 1, 0, 0, 8'h01);
        acc(8'h3f, 0, 0, 0, 0, 0);
        chk(rdata_o, 8'h01);
        acc(8'h1d, 1, 0, 3'd1, 3'd5, 0);
        acc(8'h1d, 1, 0, 3'd4, 3'd5, 0);
        chk({7'h0, bit_val_o}, 8'h01);
        acc(8'h3d, 0, 0, 3'd2, 3'd5, 0);
        acc(8'h1d, 1, 0, 0, 0, 0);
        chk(rdata_o, d | 8'h20);
        $display("address space done");
        for (a = 0; a < 6; a = a + 1) begin
            rnd = $urandom;
            p = (a == 0) ? 9'h1ff : rnd[8:0];
            acc(8'h1f, 1, 1, 0, 0, {7'h0, p[8]});
            acc(8'h1e, 1, 1, 0, 0, p[7:0]);
            @(posedge sys_clk_i);
            #1 acc(8'h1c, 1, 0, 3'd1, 3'd0, 0);
            acc(8'h1d, 1, 0, 0, 0, 0);
            chk(rdata_o, p[7:0]);
        end
        $display("reads done");
        acc(8'h1c, 1, 0, 3'd1, 3'd2, 0);
        acc(8'h1c, 1, 0, 0, 0, 0);
        chk(rdata_o, 8'h04);
        repeat (3) @(posedge sys_clk_i);
        #1 acc(8'h1c, 1, 0, 3'd1, 3'd1, 0);
        acc(8'h1c, 1, 0, 0, 0, 0);
        chk(rdata_o, 8'h00);
        $display("arm window done");
        old = p[7:0];
        for (a = 0; a < 5; a = a + 1) begin
            rnd = 32'hc9 >> (2 * a);
            act = (a == 4) ? 2'd1 : rnd[1:0];
            rnd = $urandom;
            d = rnd[7:0];
            gie_i = (a != 4);
            acc(8'h1d, 1, 1, 0, 0, d);
            acc(8'h1c, 1, 1, 0, 0, {2'b0, act, (a != 4), 3'h0});
            acc(8'h1c, 1, 0, 3'd1, 3'd2, 0);
            acc(8'h1c, 1, 0, 3'd1, 3'd1, 0);
            if (a == 4) begin
                resetn_i = 1'b0;
                repeat (2) @(posedge sys_clk_i);
                #1 resetn_i = 1'b1;
            end
            acc(8'h1c, 1, 1, 0, 0, 8'h38);
            acc(8'h1e, 1, 1, 0, 0, ~p[7:0]);
            // Read strobe under a running operation must leave the buffer alone
            if (act != 3) begin
                acc(8'h1c, 1, 0, 3'd1, 3'd0, 0);
                acc(8'h1d, 1, 0, 0, 0, 0);
                chk(rdata_o, (a == 4) ? 8'h00 : d);
            end
            acc(8'h1c, 1, 0, 0, 0, 0);
            chk(rdata_o, (act == 3) ? 8'h3c : {2'b0, act, 4'ha});
            chk({7'h0, irq_o}, {7'h0, act == 3});
            k = 0;
            while (rdata_o[1] !== 1'b0 && k < 100) begin
                acc(8'h1c, 1, 0, 0, 0, 0);
                k = k + 1;
            end
            chk({7'h0, irq_o}, {7'h0, (a != 4)});
            acc(8'h1e, 1, 0, 0, 0, 0);
            chk(rdata_o, (act == 3) ? ~p[7:0] : p[7:0]);
            acc(8'h1e, 1, 1, 0, 0, p[7:0]);
            old = f_store(act, old, d);
            @(posedge sys_clk_i);
            #1 acc(8'h1c, 1, 0, 3'd1, 3'd0, 0);
            acc(8'h1d, 1, 0, 0, 0, 0);
            chk(rdata_o, old);
        end
        $display("programming done");
        results;
    end
endmodule // nva_regs_tb
bind nva_regs nva_regs_chk #(.ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC), .PTR_W(PTR_W)) chk_u (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .rd_i(rd_i), .bit_test_i(bit_test_i),
    .gie_i(gie_i), .rdata_o(rdata_o), .bit_val_o(bit_val_o), .cpu_stall_o(cpu_stall_o),
    .irq_o(irq_o), .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
    .nvm_erase_o(nvm_erase_o), .nvm_write_o(nvm_write_o), .nvm_rd_o(nvm_rd_o));
